// ==== inc/pkt_map.vh ====
// Register map, field positions and reset values of the packet builder.
// Assumes 32-bit registers; doc bit n sits at Verilog bit 31-n.
`ifndef PKT_MAP_VH
`define PKT_MAP_VH

// ------------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------------
`define ADDR_ASYNC_HDR0 12'h1B0
`define ADDR_ASYNC_HDR1 12'h1B4
`define ADDR_ASYNC_HDR2 12'h1B8
`define ADDR_ASYNC_HDR3 12'h1BC
`define ADDR_ISO_HDR 12'h1C0
`define ADDR_CTL 12'h1C4
`define ADDR_DBC 12'h1E4

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_ASYNC_HDR0 32'h00010010
`define RST_ASYNC_HDR1 32'h3FC10000
`define RST_ASYNC_HDR2 32'h00000000
`define RST_ASYNC_HDR3 32'h00080000
`define RST_ISO_HDR 32'h00000000
`define RST_CTL 32'h80001C00
`define RST_DBC 8'h00

// ------------------------------------------------------------------
// Writable bit masks (reserved bits read zero)
// ------------------------------------------------------------------
`define MASK_ASYNC_HDR0 32'h8003FFFF
`define MASK_ISO_HDR 32'hFFFFFF3F
`define MASK_CTL 32'hB8003FF0

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define HDR0_AUTOINC 31
`define CTL_SERIAL 31
`define CTL_DV_TEST 29
`define CTL_ISO_TEST 28
`define CTL_ASYNC_TEST 27
`define CTL_MF_CTRL 13
`define CTL_MASTER_FL 12
`define CTL_CYC_FL 11
`define CTL_STAMP_FL 10
`define CTL_SOFT_RST 9
`define CTL_CELL_WE 8
`define CTL_MUX_WE 7
`define CTL_FMT_WE 6
`define CTL_DBC_WE 5
`define CTL_SPH_WE 4

// ------------------------------------------------------------------
// Speed codes and packet defaults
// ------------------------------------------------------------------
`define SPD_100 2'h0
`define SPD_200 2'h1
`define DV_DEF_QUADS 12'h008
`define DV_DEF_INC 8'h01

`endif

// ==== hw/word_fifo.v ====
// Flip-flop FIFO with a registered output stage.
// Assumes one clock and a synchronous active-high reset and flush.
`timescale 1ns/1ps

module word_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  input wire flush,
  // Filling side
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // Draining side
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  reg [AW-1:0] wr_ptr; // Next slot to fill
  reg [AW-1:0] rd_ptr; // Next slot to drain
  reg [AW:0] count; // Words held in storage
  wire push; // Word accepted
  wire pop; // Word moved to output stage

  assign in_ready = !count[AW]; // Full at DEPTH, which is 2**AW
  assign push = in_valid && in_ready;
  // Refill the output stage whenever it is empty or being taken
  assign pop = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  // ------------------------------------------------------------------
  // Pointers, count and output stage
  // ------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst || flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rd_ptr];
        rd_ptr <= rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule // word_fifo

// ==== hw/auto_packetizer_control.v ====
// Transmit auto-packetizer registers and test packet engine.
// Assumes a synchronous register port and a PHY-facing word stream.
//
// Operation
// - Autoincrement adds length after non-busy ack
// - Header word0 field bits 14-31, reset value
// - Header word1 resets to 3FC1_0000h
// - Header word2 resets to zero
// - Header word3 resets to 0008_0000h
// - Iso header field layout, bits 24-25 unused
// - Speed code 00 100M, 01 200M
// - Control bit 0 enables cycle timer serial
// - Bit 2 sends counting DV packet per cycle
// - Bit 3 sends iso test packet per cycle
// - Bit 4 sends async test packet per cycle
// - Bit 18 takes DV control from multifunction
// - Bit 19 is master flush enable
// - Bit 20 flushes on cycle start while busy
// - Bit 21 flushes on missing timestamp
// - Bit 22 resets engine, clears itself
// - Bits 23-27 gate protected field writes
// - Continuity counter auto-increments only while its writes are gated off
`timescale 1ns/1ps
`include "pkt_map.vh"

module auto_packetizer_control (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Register port
  input wire [11:0] addr,
  input wire [31:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rd_data,
  // Link events
  input wire cycle_start,
  input wire ack_valid,
  input wire ack_busy,
  input wire stamp_expected,
  input wire stamp_valid,
  input wire [31:0] mf_value,
  // Word stream toward the physical layer
  output wire [31:0] tx_data,
  output wire tx_last,
  output wire tx_valid,
  input wire tx_ready,
  output reg [1:0] tx_speed,
  output reg tx_speed_200,
  // Status and control toward the rest of the link
  output reg fifo_flush,
  output reg engine_busy,
  output wire cycle_timer_serial_out_en,
  output wire cell_size_write_en,
  output wire test_mux_write_en,
  output wire format_field_write_en,
  output wire source_hdr_flag_write_en,
  output reg [7:0] continuity_count
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  localparam ST_IDLE = 1'b0; // Waiting for a pending packet
  localparam ST_SEND = 1'b1; // Pushing header and payload words
  localparam K_DV = 2'h0; // DV test packet
  localparam K_ISO = 2'h1; // Bulk iso test packet
  localparam K_ASYNC = 2'h2; // Bulk async test packet

  reg [31:0] async_header_word0; // Autoincrement flag plus header field
  reg [31:0] async_header_word1; // Holds destination offset high
  reg [31:0] async_header_word2; // Destination offset low
  reg [31:0] async_header_word3; // Data length in top half
  reg [31:0] iso_transmit_header; // Iso header quadlet
  reg [31:0] packet_builder_control; // Control bits
  reg state; // Engine state
  reg [1:0] kind; // Packet kind in flight
  reg [2:0] pending; // One request per kind: dv, iso, async
  reg [12:0] word_idx; // Word being pushed
  reg [12:0] word_total; // Words in this packet
  reg [15:0] dv_length; // Length placed in DV header
  reg [7:0] dv_inc; // Continuity step for this DV packet
  reg [31:0] pay_count; // Incrementing payload
  reg async_sent; // Last packet sent was async
  reg [31:0] next_word; // Word presented to the FIFO
  reg [47:0] next_dest; // Incremented destination offset
  wire fifo_in_ready; // Back-pressure from the FIFO
  wire push; // Word accepted into FIFO
  wire last_word; // Final word of the packet
  wire soft_rst; // Engine reset pulse
  wire flush_now; // Flush condition this cycle
  wire dbc_write_ok; // Software may write the counter
  wire [15:0] async_len; // Async data length in bytes
  wire [11:0] iso_quads; // Iso payload quadlets
  wire [11:0] async_quads; // Async payload quadlets
  wire [11:0] dv_quads; // DV payload quadlets

  // ------------------------------------------------------------------
  // Control field decode
  // ------------------------------------------------------------------
  assign cycle_timer_serial_out_en = packet_builder_control[`CTL_SERIAL];
  assign cell_size_write_en = packet_builder_control[`CTL_CELL_WE];
  assign test_mux_write_en = packet_builder_control[`CTL_MUX_WE];
  assign format_field_write_en = packet_builder_control[`CTL_FMT_WE];
  assign source_hdr_flag_write_en = packet_builder_control[`CTL_SPH_WE];
  assign dbc_write_ok = packet_builder_control[`CTL_DBC_WE];
  assign soft_rst = packet_builder_control[`CTL_SOFT_RST];
  assign async_len = async_header_word3[31:16];
  // Odd bytes of a length are dropped
  assign iso_quads = iso_transmit_header[29:18];
  assign async_quads = async_header_word3[29:18];
  // Quadlet count is the top byte, zero-extended
  assign dv_quads = packet_builder_control[`CTL_MF_CTRL] ?
    {4'h0, mf_value[31:24]} : `DV_DEF_QUADS;

  // ------------------------------------------------------------------
  // Flush decision
  // ------------------------------------------------------------------
  // Both causes pass through the master enable; soft reset always flushes
  assign flush_now = soft_rst ||
    (packet_builder_control[`CTL_MASTER_FL] && (
     (packet_builder_control[`CTL_CYC_FL] && cycle_start &&
      state != ST_IDLE) ||
     (packet_builder_control[`CTL_STAMP_FL] && stamp_expected &&
      !stamp_valid)));

  always @(posedge clk_sys) begin
    if (rst) begin
      fifo_flush <= 1'b0;
    end else begin
      fifo_flush <= flush_now;
    end
  end

  // ------------------------------------------------------------------
  // Register writes and hardware updates
  // ------------------------------------------------------------------
  // Offset spans word1 low half and word2
  always @* begin
    next_dest = {async_header_word1[15:0], async_header_word2} +
      {32'h00000000, async_len};
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      async_header_word0 <= `RST_ASYNC_HDR0;
      async_header_word1 <= `RST_ASYNC_HDR1;
      async_header_word2 <= `RST_ASYNC_HDR2;
      async_header_word3 <= `RST_ASYNC_HDR3;
      iso_transmit_header <= `RST_ISO_HDR;
      packet_builder_control <= `RST_CTL;
    end else begin
      // Soft reset bit lives exactly one cycle after its write
      packet_builder_control[`CTL_SOFT_RST] <= 1'b0;
      // Step after a non-busy ack of our async packet
      if (ack_valid && !ack_busy && async_sent &&
          async_header_word0[`HDR0_AUTOINC]) begin
        async_header_word1[15:0] <= next_dest[47:32];
        async_header_word2 <= next_dest[31:0];
      end
      if (wr_en) begin
        case (addr)
          `ADDR_ASYNC_HDR0: begin
            async_header_word0 <= wr_data & `MASK_ASYNC_HDR0;
          end
          `ADDR_ASYNC_HDR1: async_header_word1 <= wr_data;
          `ADDR_ASYNC_HDR2: async_header_word2 <= wr_data;
          `ADDR_ASYNC_HDR3: async_header_word3 <= wr_data;
          `ADDR_ISO_HDR: begin
            iso_transmit_header <= wr_data & `MASK_ISO_HDR;
          end
          `ADDR_CTL: packet_builder_control <= wr_data & `MASK_CTL;
          default: ; // Unmapped or read-only: ignored
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Continuity counter
  // ------------------------------------------------------------------
  // Gated-off writes are dropped to keep the sequence
  always @(posedge clk_sys) begin
    if (rst) begin
      continuity_count <= `RST_DBC;
    end else if (wr_en && addr == `ADDR_DBC && dbc_write_ok) begin
      continuity_count <= wr_data[7:0];
    end else if (!dbc_write_ok && push && last_word && kind == K_DV) begin
      continuity_count <= continuity_count + dv_inc;
    end
  end

  // ------------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= 32'h00000000;
    end else if (rd_en) begin
      case (addr)
        `ADDR_ASYNC_HDR0: rd_data <= async_header_word0;
        `ADDR_ASYNC_HDR1: rd_data <= async_header_word1;
        `ADDR_ASYNC_HDR2: rd_data <= async_header_word2;
        `ADDR_ASYNC_HDR3: rd_data <= async_header_word3;
        `ADDR_ISO_HDR: rd_data <= iso_transmit_header;
        `ADDR_CTL: rd_data <= packet_builder_control;
        `ADDR_DBC: rd_data <= {24'h000000, continuity_count};
        default: rd_data <= 32'h00000000;
      endcase
    end else begin
      // Data stand for one cycle only
      rd_data <= 32'h00000000;
    end
  end

  // ------------------------------------------------------------------
  // Test packet requests
  // ------------------------------------------------------------------
  // One request per kind per cycle start; a new start beats the clear
  always @(posedge clk_sys) begin
    if (rst || soft_rst) begin
      pending <= 3'h0;
    end else begin
      if (state == ST_IDLE && pending[0]) begin
        pending[0] <= 1'b0;
      end else if (state == ST_IDLE && pending[1]) begin
        pending[1] <= 1'b0;
      end else if (state == ST_IDLE && pending[2]) begin
        pending[2] <= 1'b0;
      end
      if (cycle_start) begin
        if (packet_builder_control[`CTL_DV_TEST]) begin
          pending[0] <= 1'b1;
        end
        if (packet_builder_control[`CTL_ISO_TEST]) begin
          pending[1] <= 1'b1;
        end
        if (packet_builder_control[`CTL_ASYNC_TEST]) begin
          pending[2] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Word selection
  // ------------------------------------------------------------------
  assign last_word = (word_idx == word_total - 13'h0001);
  assign push = (state == ST_SEND) && fifo_in_ready;

  always @* begin
    next_word = pay_count;
    case (kind)
      K_DV: begin
        if (word_idx == 13'h0000) begin
          next_word = {dv_length, iso_transmit_header[15:0]};
        end else if (word_idx == 13'h0001) begin
          next_word = {24'h000000, continuity_count};
        end
      end
      K_ISO: if (word_idx == 13'h0000) next_word = iso_transmit_header;
      K_ASYNC: begin
        case (word_idx)
          13'h0000: next_word = {14'h0000, async_header_word0[17:0]};
          13'h0001: next_word = async_header_word1;
          13'h0002: next_word = async_header_word2;
          13'h0003: next_word = async_header_word3;
          default: next_word = pay_count;
        endcase
      end
      default: next_word = pay_count;
    endcase
  end

  // ------------------------------------------------------------------
  // Packet engine
  // ------------------------------------------------------------------
  // DV first, then iso, then async; each runs to its end unless a flush returns the engine to idle
  always @(posedge clk_sys) begin
    if (rst || flush_now) begin
      state <= ST_IDLE;
      kind <= K_DV;
      word_idx <= 13'h0000;
      word_total <= 13'h0000;
      dv_length <= 16'h0000;
      dv_inc <= `DV_DEF_INC;
      pay_count <= 32'h00000000;
      async_sent <= 1'b0;
      engine_busy <= 1'b0;
      tx_speed <= `SPD_100;
      tx_speed_200 <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          word_idx <= 13'h0000;
          pay_count <= 32'h00000000;
          if (pending != 3'h0) begin
            state <= ST_SEND;
            engine_busy <= 1'b1;
            tx_speed <= iso_transmit_header[5:4];
            tx_speed_200 <= (iso_transmit_header[5:4] == `SPD_200);
          end
          if (pending[0]) begin
            kind <= K_DV;
            word_total <= {1'b0, dv_quads} + 13'h0002;
            if (packet_builder_control[`CTL_MF_CTRL]) begin
              dv_length <= mf_value[23:8];
              dv_inc <= mf_value[7:0];
            end else begin
              dv_length <= iso_transmit_header[31:16];
              dv_inc <= `DV_DEF_INC;
            end
          end else if (pending[1]) begin
            kind <= K_ISO;
            word_total <= {1'b0, iso_quads} + 13'h0001;
          end else if (pending[2]) begin
            kind <= K_ASYNC;
            word_total <= {1'b0, async_quads} + 13'h0004;
            // Async test packets always go at the base rate
            tx_speed <= `SPD_100;
            tx_speed_200 <= 1'b0;
          end
        end
        ST_SEND: begin
          if (push) begin
            word_idx <= word_idx + 13'h0001;
            if (word_idx >= (kind == K_DV ? 13'h0002 :
                kind == K_ISO ? 13'h0001 : 13'h0004)) begin
              pay_count <= pay_count + 32'h00000001;
            end
            if (last_word) begin
              state <= ST_IDLE;
              engine_busy <= 1'b0;
              // No retry: the ack only steers address increment
              async_sent <= (kind == K_ASYNC);
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Transmit FIFO
  // ------------------------------------------------------------------
  // Eight words absorb PHY stalls; full FIFO holds the engine in place
  word_fifo #(.WIDTH(33), .DEPTH(8), .AW(3)) tx_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .flush(flush_now),
    .in_data({last_word, next_word}),
    .in_valid(state == ST_SEND),
    .in_ready(fifo_in_ready),
    .out_data({tx_last, tx_data}),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

endmodule // auto_packetizer_control

// ==== testbench/auto_packetizer_control_asserts.sv ====
// Checker for the packet builder register port, flushes and stream.
// Assumes it is bound onto auto_packetizer_control, one clock domain.
`timescale 1ns/1ps
`include "pkt_map.vh"
module auto_packetizer_control_asserts (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Register port
  input wire [11:0] addr,
  input wire [31:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [31:0] rd_data,
  // Link events
  input wire cycle_start,
  input wire stamp_expected,
  input wire stamp_valid,
  // Stream and status
  input wire [31:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire [1:0] tx_speed,
  input wire tx_speed_200,
  input wire fifo_flush,
  input wire engine_busy,
  input wire cycle_timer_serial_out_en,
  input wire cell_size_write_en,
  input wire test_mux_write_en,
  input wire format_field_write_en,
  input wire source_hdr_flag_write_en,
  input wire [7:0] continuity_count
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------------
  // Shadow of the control bits seen through writes
  // ------------------------------------------------------------------
  reg [3:0] fl; // Master, cycle, stamp flush, counter write enable
  reg [31:0] wd_q; // Write data of the previous cycle
  reg [2:0] soft_q; // Soft reset writes of the last three cycles
  wire ctl_wr = wr_en && addr == `ADDR_CTL;
  // Soft reset flushes before fifo_flush shows: keep a window
  always @(posedge clk_sys) begin
    wd_q <= wr_data;
    soft_q <= {soft_q[1:0], ctl_wr && wr_data[`CTL_SOFT_RST]};
    if (rst) fl <= 4'hE;
    else if (ctl_wr) fl <= {wr_data[12:10], wr_data[5]};
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  sequence s_soft; ctl_wr && wr_data[`CTL_SOFT_RST]; endsequence
  sequence s_held;
    tx_valid && !tx_ready && !fifo_flush ##1 !fifo_flush && soft_q == 3'h0;
  endsequence
  property p_soft; s_soft |-> ##[1:3] fifo_flush; endproperty
  property p_gate; fifo_flush |-> $past(fl[3]) || soft_q != 3'h0; endproperty
  property p_cyc;
    cycle_start && engine_busy && fl[3] && fl[2] |=> fifo_flush;
  endproperty
  property p_stamp;
    stamp_expected && !stamp_valid && fl[3] && fl[1] |=> fifo_flush;
  endproperty
  property p_hold; s_held |-> tx_valid && $stable(tx_data); endproperty
  property p_hdr0;
    rd_en && addr == `ADDR_ASYNC_HDR0 |=> rd_data[30:18] == 13'h0000;
  endproperty
  property p_iso; rd_en && addr == `ADDR_ISO_HDR |=> rd_data[7:6] == 2'h0;
  endproperty
  property p_spd; tx_speed_200 == (tx_speed == 2'h1); endproperty
  property p_ser;
    rd_en && addr == `ADDR_CTL |=> rd_data[31] == $past(cycle_timer_serial_out_en);
  endproperty
  property p_we; ctl_wr |=> {cell_size_write_en, test_mux_write_en,
    format_field_write_en, source_hdr_flag_write_en} ==
    {wd_q[8:6], wd_q[4]};
  endproperty
  property p_dbc; wr_en && addr == `ADDR_DBC && fl[0] |=>
    continuity_count == wd_q[7:0];
  endproperty
  a_soft: assert property (p_soft) else $error("no soft flush");
  a_gate: assert property (p_gate) else $error("flush while gated");
  a_cyc: assert property (p_cyc) else $error("no cycle flush");
  a_stamp: assert property (p_stamp) else $error("no stamp flush");
  a_hold: assert property (p_hold) else $error("word not held");
  a_hdr0: assert property (p_hdr0) else $error("reserved bits set");
  a_iso: assert property (p_iso) else $error("unused bits set");
  a_spd: assert property (p_spd) else $error("speed flag wrong");
  a_ser: assert property (p_ser) else $error("serial bit wrong");
  a_we: assert property (p_we) else $error("enable outputs wrong");
  a_dbc: assert property (p_dbc) else $error("counter not written");
endmodule // auto_packetizer_control_asserts

bind auto_packetizer_control auto_packetizer_control_asserts chk (.*);

// ==== testbench/phy_model.sv ====
// Physical layer stand-in that takes the outgoing word stream.
// Assumes one clock; ready drops at random to exercise back-pressure.
`timescale 1ns/1ps
module phy_model (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Word stream
  input wire [31:0] tx_data,
  input wire tx_last,
  input wire tx_valid,
  input wire [1:0] tx_speed,
  output reg tx_ready
);
  logic [31:0] got_q[$]; // Words taken, read by the bench
  integer pkts = 0; // Packets ended
  reg [1:0] last_spd = 2'h0; // Speed code of the last word
  // Take accepted words; stall about one beat in four
  always @(posedge clk_sys) begin
    if (rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= ($urandom % 4) != 0;
      if (tx_valid && tx_ready) begin
        got_q.push_back(tx_data);
        last_spd <= tx_speed;
        if (tx_last) pkts <= pkts + 1;
      end
    end
  end
endmodule // phy_model

// ==== testbench/tb_auto_packetizer_control.sv ====
// Bench for the packet builder: registers, test packets, flushes.
// Assumes phy_model as far side and the bound checker.
`timescale 1ns/1ps
`include "pkt_map.vh"
module tb_auto_packetizer_control;
  // Clock, reset and register port
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [11:0] addr = 12'h000;
  reg [31:0] wr_data = 32'h0;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  wire [31:0] rd_data;
  // Link events
  reg cycle_start = 1'b0;
  reg ack_valid = 1'b0;
  reg ack_busy = 1'b0;
  reg stamp_expected = 1'b0;
  reg stamp_valid = 1'b1;
  reg [31:0] mf_value = 32'h0;
  // Stream and status
  wire [31:0] tx_data;
  wire tx_last, tx_valid, tx_ready, tx_speed_200, fifo_flush, engine_busy;
  wire [1:0] tx_speed;
  wire [7:0] continuity_count;
  wire cycle_timer_serial_out_en, cell_size_write_en, test_mux_write_en;
  wire format_field_write_en, source_hdr_flag_write_en;
  wire [4:0] en = {cycle_timer_serial_out_en, cell_size_write_en,
    test_mux_write_en, format_field_write_en, source_hdr_flag_write_en};
  // Bench state
  integer errors = 0;
  integer total_checks = 0;
  integer flushes = 0; // Flush pulses seen
  integer i, m, f0;
  reg [31:0] v, iso;
  logic [31:0] exp_q[$]; // Expected words of the next packet
  localparam logic [11:0] RA [0:7] = '{`ADDR_ASYNC_HDR0, `ADDR_ASYNC_HDR1,
    `ADDR_ASYNC_HDR2, `ADDR_ASYNC_HDR3, `ADDR_ISO_HDR, `ADDR_CTL,
    `ADDR_DBC, 12'h1AC};
  localparam logic [31:0] RV [0:7] = '{32'h00010010, 32'h3FC10000,
    32'h00000000, 32'h00080000, 32'h0, 32'h80001C00, 32'h0, 32'h0};
  // 25 ns clock
  always #12.5 clk_sys = ~clk_sys;
  // Count flush pulses away from the update edge
  always @(negedge clk_sys) if (fifo_flush === 1'b1) flushes = flushes + 1;
  auto_packetizer_control dut (.*);
  phy_model phy (.*);
  // ------------------------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rdchk(input [11:0] a, input [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk(rd_data, e);
  endtask
  task pulse(input integer sel, input b);
    @(posedge clk_sys);
    cycle_start <= (sel == 0);
    ack_valid <= (sel == 1);
    ack_busy <= b;
    stamp_expected <= (sel == 2);
    stamp_valid <= (sel != 2);
    @(posedge clk_sys);
    cycle_start <= 1'b0;
    ack_valid <= 1'b0;
    stamp_expected <= 1'b0;
    stamp_valid <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask
  // One cycle start; the wait also shows no second packet follows
  task send;
    integer k, p;
    p = phy.pkts;
    pulse(0, 1'b0);
    for (k = 0; k < 600 && phy.pkts == p; k = k + 1) @(posedge clk_sys);
    repeat (12) @(posedge clk_sys);
    chk(phy.got_q.size(), exp_q.size());
    foreach (exp_q[j]) chk(phy.got_q[j], exp_q[j]);
    exp_q.delete();
    phy.got_q.delete();
  endtask
  task conclude;
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(68018));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1)
      rdchk(RA[i], RV[i]);
    // Random contents come back through the field masks
    for (i = 0; i < 6; i = i + 1) begin
      v = $urandom;
      wr(i == 5 ? 12'h1AC : RA[i], v);
      if (i == 0) v = v & 32'h8003FFFF;
      if (i == 4) v = v & 32'hFFFFFF3F;
      if (i == 5) v = 32'h0;
      rdchk(i == 5 ? 12'h1AC : RA[i], v);
    end
    // Write enables and the counter gate
    wr(`ADDR_CTL, 32'h00001DF0);
    #1 chk(en, 32'h0000000F);
    wr(`ADDR_DBC, 32'h0000005A);
    rdchk(`ADDR_DBC, 32'h0000005A);
    wr(`ADDR_CTL, 32'h00001C00);
    #1 chk(en, 32'h0);
    wr(`ADDR_DBC, 32'h000000A5);
    rdchk(`ADDR_DBC, 32'h0000005A);
    // Self-clearing engine reset
    f0 = flushes;
    wr(`ADDR_CTL, 32'h00001E00);
    rdchk(`ADDR_CTL, 32'h00001C00);
    repeat (3) @(posedge clk_sys);
    chk(flushes - f0, 32'h1);
    // Iso test packets at both speed codes
    wr(`ADDR_CTL, 32'h10001C00);
    for (m = 0; m < 2; m = m + 1) begin
      iso = 32'h00084205 | (m << 4);
      wr(`ADDR_ISO_HDR, iso);
      exp_q = '{iso, 32'h0, 32'h1};
      send;
      chk(phy.last_spd, m);
    end
    // Async test packet; only a free ack moves the address
    wr(`ADDR_CTL, 32'h08001C00);
    exp_q = '{32'h123, 32'h3FC10001, 32'hFFFFFFFC, 32'h00080000, 0, 1};
    for (i = 0; i < 4; i = i + 1) wr(RA[i], exp_q[i] | {i == 0, 31'h0});
    send;
    pulse(1, 1'b1);
    rdchk(`ADDR_ASYNC_HDR2, 32'hFFFFFFFC);
    pulse(1, 1'b0);
    rdchk(`ADDR_ASYNC_HDR1, 32'h3FC10002);
    rdchk(`ADDR_ASYNC_HDR2, 32'h00000004);
    // DV packets from the multifunction value, then from defaults
    v = 32'h5A;
    for (m = 1; m >= 0; m = m - 1) begin
      wr(`ADDR_CTL, m ? 32'h20003C00 : 32'h20001C00);
      mf_value <= 32'h03012305;
      exp_q = '{m ? {16'h0123, iso[15:0]} : iso, v};
      for (i = 0; i < (m ? 3 : 8); i = i + 1) exp_q.push_back(i);
      send;
      v = (v + (m ? 5 : 1)) & 32'hFF;
      chk(continuity_count, v);
    end
    // Flush on a new cycle while busy, on a missing stamp, gated off
    wr(`ADDR_ISO_HDR, 32'h01004205);
    wr(`ADDR_CTL, 32'h10001C00);
    f0 = flushes;
    pulse(0, 1'b0);
    for (i = 0; i < 50 && engine_busy !== 1'b1; i = i + 1)
      @(negedge clk_sys);
    pulse(0, 1'b0);
    chk(flushes - f0, 32'h1);
    pulse(2, 1'b0);
    chk(flushes - f0, 32'h2);
    wr(`ADDR_CTL, 32'h00000C00);
    pulse(2, 1'b0);
    chk(flushes - f0, 32'h2);
    conclude;
  end
  // Watchdog: the tests need a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors = errors + 1;
    conclude;
  end
endmodule // tb_auto_packetizer_control
